// >>> hw/bcq_pkg.sv
// package: register map, field positions, reset values and mode type
package bcq_pkg;
    localparam int BCQ_AW = 4;
    localparam int BCQ_DW = 8;
    localparam logic [3:0] BCQ_OFF_MODE = 4'h0;
    localparam logic [3:0] BCQ_OFF_QUAL = 4'h1;
    localparam logic [3:0] BCQ_OFF_A_EXT = 4'h2;
    localparam logic [3:0] BCQ_OFF_A_HI = 4'h3;
    localparam logic [3:0] BCQ_OFF_A_LO = 4'h4;
    localparam logic [3:0] BCQ_OFF_B_EXT = 4'h5;
    localparam logic [3:0] BCQ_OFF_B_HI = 4'h6;
    localparam logic [3:0] BCQ_OFF_B_LO = 4'h7;
    localparam logic [3:0] BCQ_OFF_STATUS = 4'h8;
    // mode register fields
    localparam int BCQ_MODE_BKEN = 7;
    localparam int BCQ_MODE_FULL = 6;
    localparam int BCQ_MODE_TREN = 5;
    // qualify control fields
    localparam int BCQ_Q_AMH = 7;
    localparam int BCQ_Q_AML = 6;
    localparam int BCQ_Q_BMH = 5;
    localparam int BCQ_Q_BML = 4;
    localparam int BCQ_Q_AEN = 3;
    localparam int BCQ_Q_AVAL = 2;
    localparam int BCQ_Q_BEN = 1;
    localparam int BCQ_Q_BVAL = 0;
    // extended register: page select in bit 6, bit 7 ignored
    localparam int BCQ_EXT_PSEL = 6;
    // status fields
    localparam int BCQ_ST_HIT_A = 0;
    localparam int BCQ_ST_HIT_B = 1;
    localparam int BCQ_ST_LEGACY = 2;
    localparam int BCQ_ST_TRACE = 3;
    localparam logic [7:0] BCQ_RST_REG = 8'h00;
    typedef enum logic [1:0] {
        BCQ_MODE_IDLE,
        BCQ_MODE_LEGACY,
        BCQ_MODE_TRACE
    } bcq_mode_t;
endpackage : bcq_pkg

// >>> hw/bcq_cmp_if.sv
// interface: one address comparator's setup and result
`timescale 1ns/10ps
interface bcq_cmp_if;
    logic [5:0] ext;
    logic [7:0] hi;
    logic [7:0] lo;
    logic mask_hi;
    logic mask_lo;
    logic page_sel;
    logic [15:0] addr;
    logic [5:0] xaddr;
    logic hit;
    modport cmp (
        input ext, hi, lo, mask_hi, mask_lo, page_sel, addr, xaddr,
        output hit
    );
    modport ctl (
        output ext, hi, lo, mask_hi, mask_lo, page_sel, addr, xaddr,
        input hit
    );
endinterface : bcq_cmp_if

// >>> hw/bcq_addr_cmp.sv
// masked address comparator, paged or 16-bit
`timescale 1ns/10ps
module bcq_addr_cmp (
    bcq_cmp_if.cmp c
);
    logic ext_eq;
    logic hi_eq;
    logic lo_eq;

    always_comb begin
        ext_eq = (c.ext == c.xaddr);
        lo_eq = (c.lo == c.addr[7:0]);
        // paged access: high byte holds only address 13:8
        if (c.page_sel) begin
            hi_eq = (c.hi[5:0] == c.addr[13:8]);
        end else begin
            hi_eq = (c.hi == c.addr[15:8]);
        end
    end

    always_comb begin
        if (!c.mask_lo) begin
            // 1:0 is nonsense, so the high mask is dropped here
            if (c.page_sel) begin
                c.hit = ext_eq && hi_eq && lo_eq;
            end else begin
                c.hit = hi_eq && lo_eq;
            end
        end else if (!c.mask_hi) begin
            c.hit = (ext_eq || !c.page_sel) && hi_eq;
        end else begin
            // whole page only: needs a paged access to match
            c.hit = c.page_sel && ext_eq;
        end
    end
endmodule : bcq_addr_cmp

// >>> hw/bcq_top.sv
// breakpoint compare qualifier: registers, masking and direction logic
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module bcq_top
    import bcq_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [BCQ_AW-1:0] reg_addr,
    input wire logic [BCQ_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [BCQ_DW-1:0] reg_rdata_q,
    input wire logic core_valid,
    input wire logic [15:0] core_addr,
    input wire logic [5:0] core_xaddr,
    input wire logic core_page_access,
    input wire logic core_read,
    input wire logic [15:0] core_data,
    output logic hit_a_q,
    output logic hit_b_q,
    output logic legacy_breakpoint_mode_q,
    output logic trace_debug_mode_q
);
    logic [7:0] mode_reg_q;
    logic [7:0] breakpoint_qualify_control_q;
    logic [7:0] cmp_a_ext_q;
    logic [7:0] cmp_a_high_byte_q;
    logic [7:0] cmp_a_low_byte_q;
    logic [7:0] cmp_b_ext_q;
    logic [7:0] cmp_b_high_byte_q;
    logic [7:0] cmp_b_low_byte_q;
    logic [7:0] rdata_d;
    bcq_mode_t mode_d;
    bcq_mode_t mode_q;
    logic breakpoint_unit_enable;
    logic trace_unit_enable;
    logic full_mode;
    logic a_mask_hi;
    logic a_mask_lo;
    logic b_mask_hi;
    logic b_mask_lo;
    logic data_hit;
    logic dir_a_ok;
    logic dir_b_ok;
    logic hit_a_d;
    logic hit_b_d;

    bcq_cmp_if cmp_a_if ();
    bcq_cmp_if cmp_b_if ();

    assign breakpoint_unit_enable = mode_reg_q[BCQ_MODE_BKEN];
    assign trace_unit_enable = mode_reg_q[BCQ_MODE_TREN];
    assign full_mode = mode_reg_q[BCQ_MODE_FULL];

    // mode register; trace enable cannot be set while breakpoint enable is set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_reg_q <= BCQ_RST_REG;
        end else if (reg_wr && reg_addr == BCQ_OFF_MODE) begin
            mode_reg_q <= reg_wdata;
            if (reg_wdata[BCQ_MODE_BKEN]) begin
                mode_reg_q[BCQ_MODE_TREN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            breakpoint_qualify_control_q <= BCQ_RST_REG;
        end else if (reg_wr && reg_addr == BCQ_OFF_QUAL) begin
            breakpoint_qualify_control_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_a_ext_q <= BCQ_RST_REG;
            cmp_a_high_byte_q <= BCQ_RST_REG;
            cmp_a_low_byte_q <= BCQ_RST_REG;
        end else if (reg_wr) begin
            if (reg_addr == BCQ_OFF_A_EXT) begin
                cmp_a_ext_q <= reg_wdata;
            end
            if (reg_addr == BCQ_OFF_A_HI) begin
                cmp_a_high_byte_q <= reg_wdata;
            end
            if (reg_addr == BCQ_OFF_A_LO) begin
                cmp_a_low_byte_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_b_ext_q <= BCQ_RST_REG;
            cmp_b_high_byte_q <= BCQ_RST_REG;
            cmp_b_low_byte_q <= BCQ_RST_REG;
        end else if (reg_wr) begin
            if (reg_addr == BCQ_OFF_B_EXT) begin
                cmp_b_ext_q <= reg_wdata;
            end
            if (reg_addr == BCQ_OFF_B_HI) begin
                cmp_b_high_byte_q <= reg_wdata;
            end
            if (reg_addr == BCQ_OFF_B_LO) begin
                cmp_b_low_byte_q <= reg_wdata;
            end
        end
    end

    // breakpoint enable wins over trace enable
    always_comb begin
        if (breakpoint_unit_enable) begin
            mode_d = BCQ_MODE_LEGACY;
        end else if (trace_unit_enable) begin
            mode_d = BCQ_MODE_TRACE;
        end else begin
            mode_d = BCQ_MODE_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= BCQ_MODE_IDLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // effective mask bits for each comparator
    always_comb begin
        a_mask_hi = 1'b0;
        a_mask_lo = 1'b0;
        b_mask_hi = 1'b0;
        b_mask_lo = 1'b0;
        unique case (mode_d)
            BCQ_MODE_LEGACY: begin
                a_mask_hi = breakpoint_qualify_control_q[BCQ_Q_AMH];
                a_mask_lo = breakpoint_qualify_control_q[BCQ_Q_AML];
                b_mask_hi = breakpoint_qualify_control_q[BCQ_Q_BMH];
                b_mask_lo = breakpoint_qualify_control_q[BCQ_Q_BML];
            end
            BCQ_MODE_TRACE: begin
                // A masks forced off; B masks only qualify data
                a_mask_hi = 1'b0;
                a_mask_lo = 1'b0;
                if (full_mode) begin
                    b_mask_hi = breakpoint_qualify_control_q[BCQ_Q_BMH];
                    b_mask_lo = breakpoint_qualify_control_q[BCQ_Q_BML];
                end
            end
            BCQ_MODE_IDLE: begin
                a_mask_hi = 1'b0;
                a_mask_lo = 1'b0;
            end
        endcase
    end

    // legacy mode pages on any paged access; trace mode needs page select too
    assign cmp_a_if.page_sel = core_page_access &&
        (mode_d == BCQ_MODE_LEGACY || cmp_a_ext_q[BCQ_EXT_PSEL]);
    assign cmp_a_if.ext = cmp_a_ext_q[5:0];
    assign cmp_a_if.hi = cmp_a_high_byte_q;
    assign cmp_a_if.lo = cmp_a_low_byte_q;
    assign cmp_a_if.mask_hi = a_mask_hi;
    assign cmp_a_if.mask_lo = a_mask_lo;
    assign cmp_a_if.addr = core_addr;
    assign cmp_a_if.xaddr = core_xaddr;

    assign cmp_b_if.page_sel = core_page_access &&
        (mode_d == BCQ_MODE_LEGACY || cmp_b_ext_q[BCQ_EXT_PSEL]);
    assign cmp_b_if.ext = cmp_b_ext_q[5:0];
    assign cmp_b_if.hi = cmp_b_high_byte_q;
    assign cmp_b_if.lo = cmp_b_low_byte_q;
    assign cmp_b_if.mask_hi = b_mask_hi;
    assign cmp_b_if.mask_lo = b_mask_lo;
    assign cmp_b_if.addr = core_addr;
    assign cmp_b_if.xaddr = core_xaddr;

    bcq_addr_cmp u_cmp_a (
        .c(cmp_a_if.cmp)
    );

    bcq_addr_cmp u_cmp_b (
        .c(cmp_b_if.cmp)
    );

    // data compare for full mode; extended bits play no part
    always_comb begin
        unique case ({b_mask_hi, b_mask_lo})
            2'b00: data_hit = (cmp_b_high_byte_q == core_data[15:8]) &&
                (cmp_b_low_byte_q == core_data[7:0]);
            2'b01: data_hit = (cmp_b_high_byte_q == core_data[15:8]);
            2'b10: data_hit = (cmp_b_low_byte_q == core_data[7:0]);
            2'b11: data_hit = 1'b1;
        endcase
    end

    // direction qualification
    always_comb begin
        dir_a_ok = 1'b1;
        if (breakpoint_qualify_control_q[BCQ_Q_AEN]) begin
            dir_a_ok = (core_read == breakpoint_qualify_control_q[BCQ_Q_AVAL]);
        end
    end

    always_comb begin
        dir_b_ok = 1'b1;
        // data cycles carry no useful direction for comparator B
        if (breakpoint_qualify_control_q[BCQ_Q_BEN] && !full_mode) begin
            dir_b_ok = (core_read == breakpoint_qualify_control_q[BCQ_Q_BVAL]);
        end
    end

    always_comb begin
        hit_a_d = 1'b0;
        hit_b_d = 1'b0;
        if (core_valid && mode_d != BCQ_MODE_IDLE) begin
            hit_a_d = cmp_a_if.hit && dir_a_ok;
            if (full_mode) begin
                hit_b_d = data_hit;
            end else begin
                hit_b_d = cmp_b_if.hit && dir_b_ok;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hit_a_q <= 1'b0;
            hit_b_q <= 1'b0;
        end else begin
            hit_a_q <= hit_a_d;
            hit_b_q <= hit_b_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            legacy_breakpoint_mode_q <= 1'b0;
            trace_debug_mode_q <= 1'b0;
        end else begin
            legacy_breakpoint_mode_q <= (mode_d == BCQ_MODE_LEGACY);
            trace_debug_mode_q <= (mode_d == BCQ_MODE_TRACE);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            BCQ_OFF_MODE: rdata_d = mode_reg_q;
            BCQ_OFF_QUAL: rdata_d = breakpoint_qualify_control_q;
            BCQ_OFF_A_EXT: rdata_d = cmp_a_ext_q;
            BCQ_OFF_A_HI: rdata_d = cmp_a_high_byte_q;
            BCQ_OFF_A_LO: rdata_d = cmp_a_low_byte_q;
            BCQ_OFF_B_EXT: rdata_d = cmp_b_ext_q;
            BCQ_OFF_B_HI: rdata_d = cmp_b_high_byte_q;
            BCQ_OFF_B_LO: rdata_d = cmp_b_low_byte_q;
            BCQ_OFF_STATUS: begin
                rdata_d[BCQ_ST_HIT_A] = hit_a_q;
                rdata_d[BCQ_ST_HIT_B] = hit_b_q;
                rdata_d[BCQ_ST_LEGACY] = (mode_q == BCQ_MODE_LEGACY);
                rdata_d[BCQ_ST_TRACE] = (mode_q == BCQ_MODE_TRACE);
            end
            default: rdata_d = 8'h00;
        endcase
    end

    // data held only in the cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end
endmodule : bcq_top

// >>> dv/bcq_core_model.sv
// core bus model: one bus cycle per call, lines toggle once released
`timescale 1ns/10ps
module bcq_core_model (
    input wire logic clk,
    output logic core_valid,
    output logic [15:0] core_addr,
    output logic [5:0] core_xaddr,
    output logic core_page_access,
    output logic core_read,
    output logic [15:0] core_data
);
    initial begin
        core_valid = 1'b0;
        core_addr = 16'h0000;
        core_xaddr = 6'h00;
        core_page_access = 1'b0;
        core_read = 1'b0;
        core_data = 16'h0000;
    end
    task automatic cycle(input logic [15:0] a, input logic [5:0] x, input logic p,
        input logic r, input logic [15:0] d);
        @(posedge clk);
        core_valid <= 1'b1;
        core_addr <= a;
        core_xaddr <= x;
        core_page_access <= p;
        core_read <= r;
        core_data <= d;
        @(posedge clk);
        // inverted leftovers so a stale value never looks like a match
        core_valid <= 1'b0;
        core_addr <= ~a;
        core_xaddr <= ~x;
        core_page_access <= ~p;
        core_read <= ~r;
        core_data <= ~d;
    endtask : cycle
endmodule : bcq_core_model

// >>> dv/bcq_top_props.sv
// checker: register bus, mode flags and hit qualification
`timescale 1ns/10ps
module bcq_top_props
    import bcq_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [BCQ_AW-1:0] reg_addr,
    input wire logic [BCQ_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [BCQ_DW-1:0] reg_rdata_q,
    input wire logic core_valid,
    input wire logic [15:0] core_addr,
    input wire logic [5:0] core_xaddr,
    input wire logic core_page_access,
    input wire logic core_read,
    input wire logic [15:0] core_data,
    input wire logic hit_a_q,
    input wire logic hit_b_q,
    input wire logic legacy_breakpoint_mode_q,
    input wire logic trace_debug_mode_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [7:0] mode_q;
    logic [7:0] qual_q;
    // shadows of the mode and qualify registers, seen from the bus
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= 8'h00;
            qual_q <= 8'h00;
        end else if (reg_wr && reg_addr == BCQ_OFF_MODE) begin
            mode_q <= reg_wdata[7] ? (reg_wdata & 8'hdf) : reg_wdata;
        end else if (reg_wr && reg_addr == BCQ_OFF_QUAL) begin
            qual_q <= reg_wdata;
        end
    end
    a_mode_exclusive: assert property (
        !(legacy_breakpoint_mode_q && trace_debug_mode_q)) else $error("both modes");
    a_legacy_follow: assert property ($stable(mode_q) |->
        legacy_breakpoint_mode_q == mode_q[7]) else $error("legacy flag off");
    a_trace_follow: assert property ($stable(mode_q) |->
        trace_debug_mode_q == (mode_q[5] && !mode_q[7])) else $error("trace flag off");
    a_hit_needs_mode: assert property (hit_a_q || hit_b_q |->
        $past(core_valid) && ($past(mode_q[7]) || $past(mode_q[5])))
        else $error("hit without cause");
    a_dir_a_match: assert property (hit_a_q && $past(qual_q[3]) |->
        $past(core_read) == $past(qual_q[2])) else $error("A direction");
    a_dir_b_match: assert property (
        hit_b_q && $past(qual_q[1]) && !$past(mode_q[6]) |->
        $past(core_read) == $past(qual_q[0])) else $error("B direction");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
        else $error("read data not idle");
    a_qual_readback: assert property (reg_rd && reg_addr == BCQ_OFF_QUAL |=>
        reg_rdata_q == $past(qual_q)) else $error("qualify readback");
    a_unmapped_zero: assert property (reg_rd && reg_addr > BCQ_OFF_STATUS |=>
        reg_rdata_q == 8'h00) else $error("unmapped read");
endmodule : bcq_top_props
bind bcq_top bcq_top_props i_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .core_valid(core_valid), .core_addr(core_addr), .core_xaddr(core_xaddr),
    .core_page_access(core_page_access), .core_read(core_read), .core_data(core_data),
    .hit_a_q(hit_a_q), .hit_b_q(hit_b_q),
    .legacy_breakpoint_mode_q(legacy_breakpoint_mode_q),
    .trace_debug_mode_q(trace_debug_mode_q));

// >>> dv/bcq_top_tb.sv
// testbench: registers, modes, masks and direction qualification
`timescale 1ns/10ps
module bcq_top_tb;
    import bcq_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata_q;
    logic core_valid, core_page_access, core_read, hit_a_q, hit_b_q, leg_q, trc_q;
    logic [15:0] core_addr, core_data;
    logic [5:0] core_xaddr;
    logic [7:0] cfg [6] = '{8'h05, 8'h12, 8'h34, 8'h07, 8'h56, 8'h78};
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    bcq_top i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .core_valid(core_valid),
        .core_addr(core_addr), .core_xaddr(core_xaddr), .core_page_access(core_page_access),
        .core_read(core_read), .core_data(core_data), .hit_a_q(hit_a_q), .hit_b_q(hit_b_q),
        .legacy_breakpoint_mode_q(leg_q), .trace_debug_mode_q(trc_q));
    bcq_core_model i_core (.clk(clk), .core_valid(core_valid), .core_addr(core_addr),
        .core_xaddr(core_xaddr), .core_page_access(core_page_access),
        .core_read(core_read), .core_data(core_data));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata_q, e);
    endtask : rd
    task automatic set(input logic [7:0] m, input logic [7:0] q);
        wr(BCQ_OFF_MODE, m);
        wr(BCQ_OFF_QUAL, q);
    endtask : set
    // a=addr x=page p=paged r=read d=data, then expected hits one cycle later
    task automatic cyc(input logic [15:0] a, input logic [5:0] x, input logic p,
        input logic r, input logic [15:0] d, input logic ea, input logic eb);
        i_core.cycle(a, x, p, r, d);
        #1;
        check({7'h00, hit_a_q}, {7'h00, ea});
        check({7'h00, hit_b_q}, {7'h00, eb});
    endtask : cyc
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // about 180 cycles needed; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) rd(4'(i), 8'h00);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        wr(BCQ_OFF_QUAL, 8'ha5);
        rd(BCQ_OFF_QUAL, 8'ha5);
        wr(BCQ_OFF_MODE, 8'ha0);
        rd(BCQ_OFF_MODE, 8'h80);
        rd(BCQ_OFF_STATUS, 8'h04);
        check({6'h00, leg_q, trc_q}, 8'h02);
        wr(BCQ_OFF_MODE, 8'h20);
        rd(BCQ_OFF_STATUS, 8'h08);
        check({6'h00, leg_q, trc_q}, 8'h01);
        foreach (cfg[i]) wr(4'(i + 2), cfg[i]);
        rd(BCQ_OFF_B_LO, 8'h78);
        set(8'h00, 8'h00);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        check({6'h00, leg_q, trc_q}, 8'h00);
        set(8'h80, 8'h00);
        cyc(16'h1234, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0);
        cyc(16'h1235, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b0);
        cyc(16'h9234, 6'h05, 1'b1, 1'b1, 16'h0000, 1'b1, 1'b0);
        cyc(16'h9234, 6'h06, 1'b1, 1'b1, 16'h0000, 1'b0, 1'b0);
        cyc(16'h5678, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1);
        wr(BCQ_OFF_QUAL, 8'h80);
        cyc(16'h1235, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h40);
        cyc(16'h12ff, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
        cyc(16'h13ff, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        wr(BCQ_OFF_QUAL, 8'hc0);
        cyc(16'h1234, 6'h05, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        cyc(16'h0000, 6'h05, 1'b1, 1'b0, 16'h0000, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h10);
        cyc(16'h56aa, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1);
        wr(BCQ_OFF_QUAL, 8'h30);
        cyc(16'h0000, 6'h07, 1'b1, 1'b0, 16'h0000, 1'b0, 1'b1);
        // direction bits only on plain address breaks, never on tagged ones
        wr(BCQ_OFF_QUAL, 8'h08);
        cyc(16'h1234, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b0);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h0c);
        cyc(16'h1234, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h04);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h02);
        cyc(16'h5678, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b0);
        cyc(16'h5678, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1);
        wr(BCQ_OFF_QUAL, 8'h03);
        cyc(16'h5678, 6'h00, 1'b0, 1'b1, 16'h0000, 1'b0, 1'b1);
        set(8'hc0, 8'h00);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h5678, 1'b1, 1'b1);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h5679, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h10);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h56ff, 1'b1, 1'b1);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h55ff, 1'b1, 1'b0);
        wr(BCQ_OFF_QUAL, 8'h20);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'hff78, 1'b1, 1'b1);
        wr(BCQ_OFF_QUAL, 8'h30);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b1);
        wr(BCQ_OFF_QUAL, 8'h03);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h5678, 1'b1, 1'b1);
        // exact breakpoints: trace mode, masks of A inert
        set(8'h20, 8'h70);
        cyc(16'h12ff, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0);
        cyc(16'h56aa, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0);
        cyc(16'h5678, 6'h00, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b1);
        set(8'h60, 8'h10);
        cyc(16'h1234, 6'h00, 1'b0, 1'b0, 16'h56ff, 1'b1, 1'b1);
        give_verdict();
    end
endmodule : bcq_top_tb
